//--- hw/wmx_cmd.sv
// AHB-Lite task file and command engine for 48-bit multiple writes.
// How it works
// - Opcode 39h accepts sectors from the host then commits them to media.
// - Interrupt raised once per block of configured size, not per sector.
// - Sector data moves host to device as 16-bit words via data port.
// - Sector count: current byte low eight bits, previous byte high eight.
// - Combined count of zero means 65,536 sectors.
// - After error, failing address readable; high-order select picks bytes.
// - Opcode CEh waits for media commit before ending status.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wmx_params.svh"
module wmx_cmd (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic IRQ,
   output logic MEDIA_REQ,
   output logic [47:0] MEDIA_LBA,
   output logic [15:0] MEDIA_WORD,
   output logic MEDIA_WORD_VALID,
   input wire logic MEDIA_ACK,
   input wire logic MEDIA_FAIL,
   output wmx_pkg::state_t STATE
);
   import wmx_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave address phase capture.
   // Write data arrives one cycle after its address, so the decoded write is
   // held as a pending flag for that data phase.
   logic wr_pend_r;
   logic rd_pend_r;
   logic [7:0] addr_r;
   logic take;
   assign take = HSEL & HREADY & HTRANS[1];
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h0;
      end else begin
         wr_pend_r <= take & HWRITE;
         rd_pend_r <= take & ~HWRITE;
         if (take) begin
            addr_r <= HADDR[7:0];
         end
      end
   end
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   function automatic logic is_wr(input logic [7:0] off);
      is_wr = wr_pend_r && addr_r == off;
   endfunction : is_wr

   ////////////////////////////////////////////////////////////////////////
   // Task file registers, each with current and previous byte except the device register.
   logic [7:0] scnt_cur_r, scnt_prev_r;
   logic [7:0] lbal_cur_r, lbal_prev_r;
   logic [7:0] lbam_cur_r, lbam_prev_r;
   logic [7:0] lbah_cur_r, lbah_prev_r;
   logic [7:0] feat_cur_r, feat_prev_r;
   logic [7:0] dev_r;
   logic [1:0] ctrl_r;
   logic [7:0] blksz_r;
   logic [2:0] irq_mask_r;
   state_t state_r;
   logic busy;
   assign busy = state_r != S_IDLE;
   // Writes push the previous byte behind the new current one.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         scnt_cur_r <= 8'h0;
         scnt_prev_r <= 8'h0;
         lbal_cur_r <= 8'h0;
         lbal_prev_r <= 8'h0;
         lbam_cur_r <= 8'h0;
         lbam_prev_r <= 8'h0;
         lbah_cur_r <= 8'h0;
         lbah_prev_r <= 8'h0;
         feat_cur_r <= 8'h0;
         feat_prev_r <= 8'h0;
         dev_r <= 8'h0;
      end else if (!busy) begin
         if (is_wr(`OFF_SCNT)) begin
            scnt_prev_r <= scnt_cur_r;
            scnt_cur_r <= HWDATA[7:0];
         end
         if (is_wr(`OFF_LBAL)) begin
            lbal_prev_r <= lbal_cur_r;
            lbal_cur_r <= HWDATA[7:0];
         end
         if (is_wr(`OFF_LBAM)) begin
            lbam_prev_r <= lbam_cur_r;
            lbam_cur_r <= HWDATA[7:0];
         end
         if (is_wr(`OFF_LBAH)) begin
            lbah_prev_r <= lbah_cur_r;
            lbah_cur_r <= HWDATA[7:0];
         end
         if (is_wr(`OFF_FEAT)) begin
            feat_prev_r <= feat_cur_r;
            feat_cur_r <= HWDATA[7:0];
         end
         if (is_wr(`OFF_DEV)) begin
            dev_r <= HWDATA[7:0];
         end
      end
   end
   // Control and mask stay writable during a command; the block size is
   // frozen then so that the running block count is not disturbed.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         ctrl_r <= 2'h0;
         blksz_r <= `BLKSZ_RESET;
         irq_mask_r <= 3'h0;
      end else begin
         if (is_wr(`OFF_CTRL)) begin
            ctrl_r <= HWDATA[1:0];
         end
         if (is_wr(`OFF_BLKSZ) && !busy) begin
            blksz_r <= HWDATA[7:0];
         end
         if (is_wr(`OFF_IRQ_MASK)) begin
            irq_mask_r <= HWDATA[2:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command engine.
   logic cmd_go, cmd_bad, cmd_fua;
   // An unknown opcode is refused with an abort and a done interrupt.
   assign cmd_go = is_wr(`OFF_CMD) && !busy;
   assign cmd_fua = HWDATA[7:0] == `OP_WR_MULT_FUA_EXT;
   assign cmd_bad = HWDATA[7:0] != `OP_WR_MULT_EXT && !cmd_fua;
   // The remaining count is one bit wider so that a zero count can stand
   // for the full 65,536 sectors.
   logic [16:0] remain_r;
   logic [8:0] words_r;
   logic [7:0] blk_left_r;
   lba_t lba_r;
   lba_t err_lba_r;
   logic fua_r;
   logic err_r, abt_r;
   logic data_wr;
   logic sector_end;
   logic media_pending, media_fail;
   lba_t media_fail_lba;
   assign data_wr = is_wr(`OFF_DATA) && state_r == S_XFER;
   // The last word of a sector ends it; the next word opens the next one.
   assign sector_end = data_wr && words_r == `WORDS_PER_SECTOR - 9'h1;

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         state_r <= S_IDLE;
         remain_r <= 17'h0;
         words_r <= 9'h0;
         blk_left_r <= 8'h0;
         lba_r <= 48'h0;
         fua_r <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (cmd_go && !cmd_bad) begin
                  state_r <= S_XFER;
                  fua_r <= cmd_fua;
                  remain_r <= {scnt_prev_r, scnt_cur_r} == 16'h0 ?
                     `MAX_SECTORS : {1'b0, scnt_prev_r, scnt_cur_r};
                  lba_r <= {lbah_prev_r, lbam_prev_r, lbal_prev_r,
                     lbah_cur_r, lbam_cur_r, lbal_cur_r};
                  words_r <= 9'h0;
                  blk_left_r <= blksz_r;
               end
            end
            S_XFER: begin
               if (media_fail) begin
                  state_r <= S_DONE;
               end else if (data_wr) begin
                  words_r <= sector_end ? 9'h0 : words_r + 9'h1;
                  if (sector_end) begin
                     remain_r <= remain_r - 17'h1;
                     lba_r <= lba_r + 48'h1;
                     blk_left_r <= blk_left_r - 8'h1;
                     if (remain_r == 17'h1) begin
                        state_r <= S_COMMIT;
                     end else if (blk_left_r == 8'h1) begin
                        state_r <= S_BLOCK;
                     end
                  end
               end
            end
            // No data is taken here; the host sees the data request low and
            // waits for the block interrupt before it sends the next block.
            S_BLOCK: begin
               blk_left_r <= blksz_r;
               state_r <= S_XFER;
            end
            S_COMMIT: begin
               // With the cache on and no forced commit nothing is pending,
               // so the command ends at once.
               if (media_fail || !media_pending) begin
                  state_r <= S_DONE;
               end
            end
            S_DONE: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // Error capture keeps the first unrecoverable sector.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         err_r <= 1'b0;
         abt_r <= 1'b0;
         err_lba_r <= 48'h0;
      end else if (cmd_go) begin
         err_r <= cmd_bad;
         abt_r <= cmd_bad;
      end else if (media_fail && !err_r && busy) begin
         err_r <= 1'b1;
         err_lba_r <= media_fail_lba;
      end
   end

   // Commits are awaited when the command forces them or the cache is off.
   wmx_media_port u_media (
      .MCLK(MCLK),
      .NRST(NRST),
      .sector_done(sector_end),
      .sector_lba(lba_r),
      .write_through(fua_r | ~ctrl_r[`CTRL_WCACHE]),
      .commit_req(MEDIA_REQ),
      .commit_lba(MEDIA_LBA),
      .commit_ack(MEDIA_ACK),
      .commit_fail(MEDIA_FAIL),
      .pending(media_pending),
      .fail_pulse(media_fail),
      .fail_lba(media_fail_lba)
   );

   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         MEDIA_WORD <= 16'h0;
         MEDIA_WORD_VALID <= 1'b0;
      end else begin
         MEDIA_WORD_VALID <= data_wr;
         if (data_wr) begin
            MEDIA_WORD <= HWDATA[15:0];
         end
      end
   end
   // The state is brought out for the checker and for debug.
   assign STATE = state_r;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over the clear by read.
   logic [2:0] irq_stat_r;
   logic [2:0] irq_set;
   logic rd_irq;
   assign irq_set = {state_r == S_DONE && err_r,
      state_r == S_DONE || (cmd_go && cmd_bad), state_r == S_BLOCK};
   assign rd_irq = rd_pend_r && addr_r == `OFF_IRQ_STAT;
   // Only the bits that the read returned are cleared, so an event that
   // lands between the address phase and the data phase is kept.
   logic [2:0] irq_seen_r;
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         irq_seen_r <= 3'h0;
      end else if (take && !HWRITE) begin
         irq_seen_r <= irq_stat_r;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         irq_stat_r <= 3'h0;
      end else begin
         irq_stat_r <= (rd_irq ? irq_stat_r & ~irq_seen_r : irq_stat_r)
            | irq_set;
      end
   end
   assign IRQ = |(irq_stat_r & irq_mask_r);

   ////////////////////////////////////////////////////////////////////////
   // Read data path.
   logic [7:0] status;
   logic [7:0] errflags;
   logic hob;
   lba_t shown;
   assign hob = ctrl_r[`CTRL_HOB];
   // After a failed command the address registers show the failing sector.
   assign shown = err_r ? err_lba_r : lba_r;
   // Busy while a command runs outside the transfer phase, data request inside it.
   always_comb begin
      status = 8'h0;
      status[`ST_BSY] = busy && state_r != S_XFER;
      status[`ST_RDY] = 1'b1;
      status[`ST_DSC] = 1'b1;
      status[`ST_DRQ] = state_r == S_XFER;
      status[`ST_ERR] = err_r;
      errflags = 8'h0;
      errflags[`ER_ABT] = abt_r;
      errflags[`ER_IDN] = err_r & ~abt_r;
   end
   // Read data is captured at the address phase, so it stands through the
   // data phase with no wait state.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         HRDATA <= 32'h0;
      end else if (take && !HWRITE) begin
         case (HADDR[7:0])
            `OFF_SCNT: HRDATA <= {24'h0, hob ? remain_r[15:8] : remain_r[7:0]};
            `OFF_LBAL: HRDATA <= {24'h0, hob ? shown[31:24] : shown[7:0]};
            `OFF_LBAM: HRDATA <= {24'h0, hob ? shown[39:32] : shown[15:8]};
            `OFF_LBAH: HRDATA <= {24'h0, hob ? shown[47:40] : shown[23:16]};
            `OFF_DEV: HRDATA <= {24'h0, dev_r};
            `OFF_ERR: HRDATA <= {24'h0, errflags};
            `OFF_STAT: HRDATA <= {24'h0, status};
            `OFF_CTRL: HRDATA <= {30'h0, ctrl_r};
            `OFF_IRQ_STAT: HRDATA <= {29'h0, irq_stat_r};
            `OFF_IRQ_MASK: HRDATA <= {29'h0, irq_mask_r};
            `OFF_BLKSZ: HRDATA <= {24'h0, blksz_r};
            `OFF_FEAT: HRDATA <= {16'h0, feat_prev_r, feat_cur_r};
            default: HRDATA <= 32'h0;
         endcase
      end
   end
endmodule : wmx_cmd
`default_nettype wire

//--- hw/wmx_media_port.sv
// Media commit engine: hands each finished sector to the media interface.
`timescale 1ns/1ps
`default_nettype none
module wmx_media_port (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic sector_done,
   input wire logic [47:0] sector_lba,
   input wire logic write_through,
   output logic commit_req,
   output logic [47:0] commit_lba,
   input wire logic commit_ack,
   input wire logic commit_fail,
   output logic pending,
   output logic fail_pulse,
   output logic [47:0] fail_lba
);
   // Sectors queued but not acknowledged by the media.
   logic [16:0] outstanding_r;
   logic ack_r;
   assign pending = write_through ? (outstanding_r != 17'h0) : 1'b0;
   assign ack_r = commit_req & commit_ack;
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         outstanding_r <= 17'h0;
      end else begin
         outstanding_r <= outstanding_r + {16'h0, sector_done}
            - {16'h0, ack_r};
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         commit_req <= 1'b0;
         commit_lba <= 48'h0;
      end else if (sector_done) begin
         commit_req <= 1'b1;
         commit_lba <= sector_lba;
      end else if (ack_r && outstanding_r <= 17'h1) begin
         commit_req <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         fail_pulse <= 1'b0;
         fail_lba <= 48'h0;
      end else begin
         fail_pulse <= ack_r & commit_fail;
         if (ack_r && commit_fail) begin
            fail_lba <= commit_lba;
         end
      end
   end
endmodule : wmx_media_port
`default_nettype wire

//--- hw/wmx_params.svh
// Register offsets, field positions, reset values and opcodes.
`ifndef WMX_PARAMS_SVH
`define WMX_PARAMS_SVH
`define OFF_DATA 8'h00
`define OFF_FEAT 8'h04
`define OFF_SCNT 8'h08
`define OFF_LBAL 8'h0c
`define OFF_LBAM 8'h10
`define OFF_LBAH 8'h14
`define OFF_DEV 8'h18
`define OFF_CMD 8'h1c
`define OFF_ERR 8'h20
`define OFF_STAT 8'h24
`define OFF_CTRL 8'h28
`define OFF_IRQ_STAT 8'h2c
`define OFF_IRQ_MASK 8'h30
`define OFF_BLKSZ 8'h34
`define OFF_MEDIA 8'h38
`define OP_WR_MULT_EXT 8'h39
`define OP_WR_MULT_FUA_EXT 8'hce
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_IDN 4
`define ER_ABT 2
`define CTRL_HOB 0
`define CTRL_WCACHE 1
`define IRQ_BLOCK 0
`define IRQ_DONE 1
`define IRQ_ERROR 2
`define WORDS_PER_SECTOR 9'h100
`define MAX_SECTORS 17'h10000
`define BLKSZ_RESET 8'h10
`define STAT_RESET 8'h50
`endif

//--- hw/wmx_pkg.sv
// Types shared by the multiple-sector write command block.
package wmx_pkg;
   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_XFER = 5'b00010,
      S_BLOCK = 5'b00100,
      S_COMMIT = 5'b01000,
      S_DONE = 5'b10000
   } state_t;
   typedef logic [47:0] lba_t;
endpackage : wmx_pkg

//--- sim/test_ata_write_multiple_ext_cmd.sv
// Self-checking bench for the multiple-sector write command block.
`timescale 1ns/1ps
`default_nettype none
`include "wmx_params.svh"
module test_ata_write_multiple_ext_cmd;
   import wmx_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy, irq;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, hrdata;
   logic [1:0] htrans = 2'b00;
   logic [3:0] lat = 4'h2;
   logic fail_on = 1'b0, mreq, mack, mfail, wv;
   logic [15:0] mword;
   logic [47:0] mlba;
   int acks, words = 0, error_cnt = 0, check_count = 0;
   state_t st;
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (wv === 1'b1) words <= words + 1;
   wmx_cmd dut (.MCLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
      .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(),
      .IRQ(irq), .MEDIA_REQ(mreq), .MEDIA_LBA(mlba), .MEDIA_WORD(mword),
      .MEDIA_WORD_VALID(wv), .MEDIA_ACK(mack), .MEDIA_FAIL(mfail),
      .STATE(st));
   wmx_media_model media (.MCLK(clk), .NRST(nrst), .req(mreq), .lat(lat),
      .fail_on(fail_on), .ack(mack), .fail(mfail), .acks(acks));
   ///////////////////////////////////////////////////////////////////////
   task close_out;
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      q = hrdata;
   endtask : bus
   task ld(input logic [15:0] n, input logic [47:0] a);
      bus(1, `OFF_SCNT, n[15:8]);
      bus(1, `OFF_SCNT, n[7:0]);
      for (int i = 0; i < 3; i++) begin
         bus(1, `OFF_LBAL + 8'(4 * i), a[31 + 8 * i -: 8]);
         bus(1, `OFF_LBAL + 8'(4 * i), a[7 + 8 * i -: 8]);
      end
   endtask : ld
   task sec(input logic [15:0] b);
      for (int i = 0; i < 256; i++) bus(1, `OFF_DATA, b + 16'(i));
      repeat (4) @(posedge clk);
   endtask : sec
   task wait_irq;
      for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge clk);
      chk(irq, 1);
   endtask : wait_irq
   ///////////////////////////////////////////////////////////////////////
   task t_reset;
      bus(0, `OFF_STAT, 0); chk(q[7:0], `STAT_RESET);
      bus(0, `OFF_BLKSZ, 0); chk(q[7:0], `BLKSZ_RESET);
      bus(0, 8'h3c, 0); chk(q, 0);
      chk(irq, 0);
   endtask : t_reset
   task t_blocks;
      bus(1, `OFF_CTRL, 2);
      bus(1, `OFF_BLKSZ, 2);
      bus(1, `OFF_IRQ_MASK, 7);
      ld(16'h0003, 48'h0a0b0c0d0e0f);
      bus(1, `OFF_CMD, `OP_WR_MULT_EXT);
      bus(0, `OFF_STAT, 0); chk(q[`ST_DRQ], 1);
      sec(16'h1000); chk(irq, 0);
      chk(mlba, 48'h0a0b0c0d0e0f);
      sec(16'h2000); chk(irq, 1);
      bus(0, `OFF_IRQ_STAT, 0); chk(q[2:0], 3'b001);
      @(posedge clk);
      chk(irq, 0);
      sec(16'h3000); chk(mword, 16'h30ff);
      wait_irq();
      bus(0, `OFF_IRQ_STAT, 0); chk(q[2:0], 3'b010);
      chk(words, 768);
   endtask : t_blocks
   task t_fua;
      int a0;
      for (int i = 0; i < 200 && mreq !== 1'b0; i++) @(posedge clk);
      a0 = acks;
      lat <= 4'hc;
      ld(16'h0002, 48'h000000000100);
      bus(1, `OFF_CMD, `OP_WR_MULT_FUA_EXT);
      sec(16'h4000);
      sec(16'h5000);
      bus(0, `OFF_STAT, 0); chk(q[`ST_BSY], 1);
      wait_irq();
      chk(acks - a0, 2);
      bus(0, `OFF_IRQ_STAT, 0); chk(q[2:0], 3'b010);
      lat <= 4'h2;
   endtask : t_fua
   task t_fail;
      fail_on <= 1'b1;
      ld(16'h0002, 48'h112233445566);
      bus(1, `OFF_CMD, `OP_WR_MULT_EXT);
      sec(16'h6000);
      wait_irq();
      fail_on <= 1'b0;
      bus(0, `OFF_IRQ_STAT, 0); chk(q[2:0], 3'b110);
      bus(0, `OFF_ERR, 0); chk(q[`ER_IDN], 1);
      bus(0, `OFF_STAT, 0); chk(q[`ST_ERR], 1);
      bus(0, `OFF_LBAL, 0); chk(q[7:0], 8'h66);
      bus(0, `OFF_LBAH, 0); chk(q[7:0], 8'h44);
      bus(1, `OFF_CTRL, 3);
      bus(0, `OFF_LBAL, 0); chk(q[7:0], 8'h33);
      bus(0, `OFF_LBAM, 0); chk(q[7:0], 8'h22);
      bus(0, `OFF_LBAH, 0); chk(q[7:0], 8'h11);
   endtask : t_fail
   task t_zero;
      bus(1, `OFF_CMD, 8'h00);
      bus(0, `OFF_ERR, 0); chk(q[`ER_ABT], 1);
      ld(16'h0000, 48'h0);
      bus(1, `OFF_CMD, `OP_WR_MULT_EXT);
      bus(0, `OFF_SCNT, 0); chk(q[7:0], 8'h00);
      sec(16'h7000);
      bus(0, `OFF_SCNT, 0); chk(q[7:0], 8'hff);
      bus(1, `OFF_CTRL, 2);
      bus(0, `OFF_SCNT, 0); chk(q[7:0], 8'hff);
      bus(0, `OFF_STAT, 0); chk(q[`ST_DRQ], 1);
   endtask : t_zero
   ///////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_reset();
      t_blocks();
      t_fua();
      t_fail();
      t_zero();
      close_out();
   end
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      close_out();
   end
endmodule : test_ata_write_multiple_ext_cmd
`default_nettype wire

//--- sim/wmx_cmd_properties.sv
// Port-level checker for the multiple-sector write command block.
`timescale 1ns/1ps
`default_nettype none
`include "wmx_params.svh"
module wmx_cmd_properties
   import wmx_pkg::*;
(
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic MEDIA_REQ,
   input wire logic [15:0] MEDIA_WORD,
   input wire logic MEDIA_WORD_VALID,
   input wire logic MEDIA_ACK,
   input wire wmx_pkg::state_t STATE
);
   logic cph_r;
   logic fua_r;
   logic take;
   assign take = HSEL && HREADY && HTRANS[1];
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) cph_r <= 1'b0;
      else cph_r <= take && HWRITE && HADDR[7:0] == `OFF_CMD;
   end
   // Remembers whether the running command is the forced-commit one.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) fua_r <= 1'b0;
      else if (cph_r && STATE == S_IDLE)
         fua_r <= HWDATA[7:0] == `OP_WR_MULT_FUA_EXT;
   end
   chk_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not zero-wait okay");
   chk_state_onehot: assert property ($onehot(STATE))
      else $error("state not one-hot");
   chk_word_pulse: assert property ((take && HWRITE &&
      HADDR[7:0] == `OFF_DATA && STATE == S_XFER) ##1 (STATE == S_XFER)
      |=> (MEDIA_WORD_VALID && MEDIA_WORD == $past(HWDATA[15:0])))
      else $error("data word not passed on");
   chk_word_cause: assert property (MEDIA_WORD_VALID |->
      $past(HWRITE, 2) && $past(HTRANS[1], 2))
      else $error("data word without a write");
   chk_block_once: assert property (STATE == S_BLOCK |=>
      STATE != S_BLOCK) else $error("block state held");
   chk_done_once: assert property (STATE == S_DONE |=> STATE == S_IDLE)
      else $error("done state not followed by idle");
   chk_fua_wait: assert property (STATE == S_COMMIT && fua_r &&
      MEDIA_REQ && !MEDIA_ACK && !$past(MEDIA_ACK) |=> STATE != S_DONE)
      else $error("forced commit ended early");
   chk_unmapped_zero: assert property (take && !HWRITE &&
      HADDR[7:0] > `OFF_MEDIA |=> HRDATA == 32'h0)
      else $error("unmapped read not zero");
endmodule : wmx_cmd_properties
bind wmx_cmd wmx_cmd_properties chk (
   .MCLK(MCLK),
   .NRST(NRST),
   .HSEL(HSEL),
   .HADDR(HADDR),
   .HTRANS(HTRANS),
   .HWRITE(HWRITE),
   .HWDATA(HWDATA),
   .HREADY(HREADY),
   .HRDATA(HRDATA),
   .HREADYOUT(HREADYOUT),
   .HRESP(HRESP),
   .MEDIA_REQ(MEDIA_REQ),
   .MEDIA_WORD(MEDIA_WORD),
   .MEDIA_WORD_VALID(MEDIA_WORD_VALID),
   .MEDIA_ACK(MEDIA_ACK),
   .STATE(STATE)
);
`default_nettype wire

//--- sim/wmx_media_model.sv
// Behavioural media side that acknowledges sector commits after a delay.
`timescale 1ns/1ps
`default_nettype none
module wmx_media_model (
   input wire logic MCLK,
   input wire logic NRST,
   input wire logic req,
   input wire logic [3:0] lat,
   input wire logic fail_on,
   output logic ack,
   output logic fail,
   output int acks
);
   logic [3:0] cnt_r;
   // The delay restarts after each ack, so a request that is still high
   // for a cycle after an ack is not answered twice.
   always_ff @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         ack <= 1'b0;
         fail <= 1'b0;
         cnt_r <= 4'h0;
         acks <= 0;
      end else begin
         ack <= 1'b0;
         fail <= 1'b0;
         if (req && !ack) begin
            if (cnt_r >= lat) begin
               ack <= 1'b1;
               fail <= fail_on;
               cnt_r <= 4'h0;
               acks <= acks + 1;
            end else begin
               cnt_r <= cnt_r + 4'h1;
            end
         end
      end
   end
endmodule : wmx_media_model
`default_nettype wire
